// ==== logic/acsp_cfg.svh ====
`ifndef ACSP_CFG_SVH
`define ACSP_CFG_SVH

// -----------------------------------------------------------------------------
// Word formats
// -----------------------------------------------------------------------------
`define ACSP_LIN_W 14
`define ACSP_COMP_W 8
`define ACSP_CODE_W 4
`define ACSP_CNT_W 4
`define ACSP_LIN_BITS 4'hE
`define ACSP_COMP_BITS 4'h8
`define ACSP_CODE_BITS 4'h4
// Companded characters have alternate bits inverted on the line.
`define ACSP_COMP_MASK 8'h55
// Largest companded magnitude.
`define ACSP_MAG_MAX 14'h1FFF

// -----------------------------------------------------------------------------
// Adaptive quantiser
// -----------------------------------------------------------------------------
`define ACSP_SCALE_W 4
`define ACSP_SCALE_MAX 4'h9
`define ACSP_SCALE_RST 4'h0
`define ACSP_PRED_RST 14'h0000
`define ACSP_STEP_BASE 4
`define ACSP_MAG_HI 3'h6
`define ACSP_MAG_LO 3'h1
`define ACSP_POS_MAX 17'sh01FFF
`define ACSP_NEG_MIN -17'sh02000

// -----------------------------------------------------------------------------
// Pin synchroniser and receive buffer
// -----------------------------------------------------------------------------
`define ACSP_SYNC_W 10
`define ACSP_FIFO_DEPTH 2

`endif

// ==== logic/acsp_codec_port.sv ====
`include "acsp_cfg.svh"

module acsp_codec_port (
   input wire logic clk,
   input wire logic srst,
   input wire logic law_select,
   input wire logic power_down_n,
   input wire logic algorithm_init_n,
   input wire logic pcm_bit_clock,
   input wire logic adpcm_bit_clock,
   input wire logic tx_frame_sync,
   input wire logic rx_frame_sync,
   input wire logic pcm_tx_in,
   input wire logic pcm_rx_in,
   input wire logic adpcm_rx_in,
   input wire logic [13:0] tx_sample_data,
   output logic tx_sample_taken,
   output logic pcm_tx_out,
   output logic pcm_rx_out,
   output logic adpcm_tx_out_o,
   output logic adpcm_tx_out_oe,
   output logic [13:0] dac_sample,
   output logic dac_sample_valid,
   output logic powered_down
);

   // -----------------------------------------------------------------------------
   // Helper functions
   // -----------------------------------------------------------------------------

   // Linear sample to companded character.
   function automatic logic [7:0] comp_encode(input logic [13:0] x);
      logic [13:0] m;
      logic [13:0] sh;
      logic [2:0] seg;
      m = x[13] ? 14'(-x) : x;
      if (m > `ACSP_MAG_MAX) m = `ACSP_MAG_MAX;
      seg = 3'h0;
      for (int k = 1; k < 8; k++) begin
         if (m >= (14'h0020 << (k - 1))) seg = 3'(k);
      end
      sh = (seg == 3'h0) ? m : (m >> (seg - 3'h1));
      return {~x[13], seg, sh[4:1]} ^ `ACSP_COMP_MASK;
   endfunction : comp_encode

   // Companded character to linear sample.
   function automatic logic [13:0] comp_decode(input logic [7:0] c);
      logic [7:0] u;
      logic [13:0] mag;
      u = c ^ `ACSP_COMP_MASK;
      if (u[6:4] == 3'h0) mag = {9'h000, u[3:0], 1'b1};
      else mag = {8'h00, 1'b1, u[3:0], 1'b1} << (u[6:4] - 3'h1);
      return u[7] ? mag : 14'(-mag);
   endfunction : comp_decode

   // Quantise the prediction error to sign and three magnitude bits.
   function automatic logic [3:0] quantise(input logic [13:0] x, input acsp_pkg::acsp_adpcm_t st);
      logic signed [14:0] d;
      logic [14:0] a;
      logic [14:0] q;
      d = 15'($signed(x)) - 15'(st.pred);
      a = d[14] ? 15'(-d) : 15'(d);
      q = a >> (st.scale + 4'(`ACSP_STEP_BASE));
      return {d[14], (q > 15'h0007) ? 3'h7 : q[2:0]};
   endfunction : quantise

   // Rebuild the prediction and adapt the step from one codeword.
   function automatic acsp_pkg::acsp_adpcm_t adapt(input acsp_pkg::acsp_adpcm_t st,
                                                  input logic [3:0] code);
      acsp_pkg::acsp_adpcm_t nx;
      logic [16:0] dq;
      logic signed [16:0] p;
      dq = 17'({code[2:0], 1'b1}) << (st.scale + 4'(`ACSP_STEP_BASE - 1));
      p = code[3] ? (17'(st.pred) - $signed(dq)) : (17'(st.pred) + $signed(dq));
      if (p > `ACSP_POS_MAX) p = `ACSP_POS_MAX;
      if (p < `ACSP_NEG_MIN) p = `ACSP_NEG_MIN;
      nx.pred = 14'(p);
      nx.scale = st.scale;
      if (code[2:0] >= `ACSP_MAG_HI && st.scale < `ACSP_SCALE_MAX) nx.scale = st.scale + 4'h1;
      if (code[2:0] <= `ACSP_MAG_LO && st.scale != 4'h0) nx.scale = st.scale - 4'h1;
      return nx;
   endfunction : adapt

   // -----------------------------------------------------------------------------
   // Pin synchronisation and edge detection
   // -----------------------------------------------------------------------------
   logic [9:0] pins_s;
   logic pclk_s;
   logic aclk_s;
   logic txfs_s;
   logic rxfs_s;
   logic ptxi_s;
   logic prxi_s;
   logic arxi_s;
   logic law_s;
   logic pdn_s;
   logic init_s;

   // The ten serial and control pins are asynchronous to clk, so each passes the synchroniser; tx_sample_data does not.
   acsp_sync #(.W(`ACSP_SYNC_W)) u_sync (
      .clk(clk),
      .srst(srst),
      .d_async({law_select, power_down_n, algorithm_init_n, pcm_bit_clock, adpcm_bit_clock,
                tx_frame_sync, rx_frame_sync, pcm_tx_in, pcm_rx_in, adpcm_rx_in}),
      .q(pins_s)
   );
   assign {law_s, pdn_s, init_s, pclk_s, aclk_s, txfs_s, rxfs_s, ptxi_s, prxi_s, arxi_s} = pins_s;

   logic pclk_d_r;
   logic aclk_d_r;
   logic p_txfs_r;
   logic p_rxfs_r;
   logic a_txfs_r;
   logic a_rxfs_r;
   logic p_rise;
   logic p_fall;
   logic a_rise;
   logic a_fall;
   logic p_tx_start;
   logic p_rx_start;
   logic a_tx_start;
   logic a_rx_start;

   // Bit-clock edges; a frame starts at the first rise that sees its sync high.
   assign p_rise = pclk_s & ~pclk_d_r;
   assign p_fall = ~pclk_s & pclk_d_r;
   assign a_rise = aclk_s & ~aclk_d_r;
   assign a_fall = ~aclk_s & aclk_d_r;
   assign p_tx_start = p_rise & txfs_s & ~p_txfs_r;
   assign p_rx_start = p_rise & rxfs_s & ~p_rxfs_r;
   assign a_tx_start = a_rise & txfs_s & ~a_txfs_r;
   assign a_rx_start = a_rise & rxfs_s & ~a_rxfs_r;

   // Remember each sync level as seen at the last rise of each bit clock.
   always_ff @(posedge clk) begin
      if (srst) begin
         {pclk_d_r, aclk_d_r, p_txfs_r, p_rxfs_r, a_txfs_r, a_rxfs_r} <= 6'h00;
      end else begin
         pclk_d_r <= pclk_s;
         aclk_d_r <= aclk_s;
         if (p_rise) {p_txfs_r, p_rxfs_r} <= {txfs_s, rxfs_s};
         if (a_rise) {a_txfs_r, a_rxfs_r} <= {txfs_s, rxfs_s};
      end
   end

   // -----------------------------------------------------------------------------
   // Operating mode
   // -----------------------------------------------------------------------------
   acsp_pkg::acsp_mode_t mode_r;
   acsp_pkg::acsp_mode_t mode_nxt;
   logic off;
   logic hold;

   // Power-down outranks the algorithm reset.
   always_comb begin
      case ({pdn_s, init_s})
         2'b10: mode_nxt = acsp_pkg::ACSP_INIT;
         2'b11: mode_nxt = acsp_pkg::ACSP_RUN;
         default: mode_nxt = acsp_pkg::ACSP_OFF;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) mode_r <= acsp_pkg::ACSP_OFF;
      else mode_r <= mode_nxt;
   end

   assign off = (mode_r == acsp_pkg::ACSP_OFF);
   assign hold = (mode_r != acsp_pkg::ACSP_RUN);

   // Word length follows the coding law.
   logic [3:0] pcm_bits;
   assign pcm_bits = law_s ? `ACSP_LIN_BITS : `ACSP_COMP_BITS;

   // -----------------------------------------------------------------------------
   // Transmit PCM serialiser
   // -----------------------------------------------------------------------------
   logic [13:0] ptx_sh_r;
   logic [13:0] ptx_load;
   logic pcm_tx_out_r;
   logic taken_r;

   // Companded characters sit MSB-aligned; zeros follow the last bit.
   assign ptx_load = law_s ? tx_sample_data : {comp_encode(tx_sample_data), 6'h00};

   always_ff @(posedge clk) begin
      if (srst || off) begin
         ptx_sh_r <= 14'h0000;
         pcm_tx_out_r <= 1'b0;
         taken_r <= 1'b0;
      end else begin
         taken_r <= p_tx_start;
         if (p_tx_start) begin
            ptx_sh_r <= {ptx_load[12:0], 1'b0};
            pcm_tx_out_r <= ptx_load[13];
         end else if (p_rise) begin
            ptx_sh_r <= {ptx_sh_r[12:0], 1'b0};
            pcm_tx_out_r <= ptx_sh_r[13];
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Transmit PCM capture and ADPCM coder
   // -----------------------------------------------------------------------------
   logic [13:0] ptxi_sh_r;
   logic [3:0] ptxi_cnt_r;
   logic ptxi_done;
   logic [13:0] ptxi_word;
   logic [13:0] ptxi_lin;
   logic [3:0] enc_code;
   acsp_pkg::acsp_adpcm_t enc_st_r;
   logic [3:0] enc_code_r;

   assign ptxi_done = p_fall && (ptxi_cnt_r == 4'h1);
   assign ptxi_word = {ptxi_sh_r[12:0], ptxi_s};
   assign ptxi_lin = law_s ? ptxi_word : comp_decode(ptxi_word[7:0]);
   assign enc_code = quantise(ptxi_lin, enc_st_r);

   // Count down one word of falling-edge samples after each frame start.
   always_ff @(posedge clk) begin
      if (srst || off) begin
         ptxi_sh_r <= 14'h0000;
         ptxi_cnt_r <= 4'h0;
      end else if (p_tx_start) begin
         ptxi_cnt_r <= pcm_bits;
      end else if (p_fall && ptxi_cnt_r != 4'h0) begin
         ptxi_sh_r <= ptxi_word;
         ptxi_cnt_r <= ptxi_cnt_r - 4'h1;
      end
   end

   // One codeword per transmit frame.
   always_ff @(posedge clk) begin
      if (srst || hold) begin
         enc_st_r <= '{pred: `ACSP_PRED_RST, scale: `ACSP_SCALE_RST};
         enc_code_r <= 4'h0;
      end else if (ptxi_done) begin
         enc_st_r <= adapt(enc_st_r, enc_code);
         enc_code_r <= enc_code;
      end
   end

   // -----------------------------------------------------------------------------
   // Transmit ADPCM open-drain output
   // -----------------------------------------------------------------------------
   logic [3:0] atx_sh_r;
   logic [3:0] atx_live_r;
   logic atx_oe_r;

   // The line is pulled low for a zero and released for a one or when idle.
   always_ff @(posedge clk) begin
      if (srst || off) begin
         atx_sh_r <= 4'h0;
         atx_live_r <= 4'h0;
         atx_oe_r <= 1'b0;
      end else if (a_tx_start) begin
         atx_sh_r <= {enc_code_r[2:0], 1'b0};
         atx_live_r <= 4'hE;
         atx_oe_r <= ~enc_code_r[3];
      end else if (a_rise) begin
         atx_sh_r <= {atx_sh_r[2:0], 1'b0};
         atx_live_r <= {atx_live_r[2:0], 1'b0};
         atx_oe_r <= atx_live_r[3] & ~atx_sh_r[3];
      end
   end

   // -----------------------------------------------------------------------------
   // Receive ADPCM capture and decoder
   // -----------------------------------------------------------------------------
   logic [3:0] arx_sh_r;
   logic [2:0] arx_cnt_r;
   logic [3:0] arx_code_r;
   logic arx_pend_r;
   logic arx_done;
   logic dec_push;
   logic fifo_in_ready;
   acsp_pkg::acsp_adpcm_t dec_st_r;
   acsp_pkg::acsp_adpcm_t dec_next;

   assign arx_done = a_fall && (arx_cnt_r == 3'h1);
   assign dec_push = arx_pend_r & fifo_in_ready;
   assign dec_next = adapt(dec_st_r, arx_code_r);

   // Four bits per receive frame, taken on falling edges.
   always_ff @(posedge clk) begin
      if (srst || off) begin
         arx_sh_r <= 4'h0;
         arx_cnt_r <= 3'h0;
      end else if (a_rx_start) begin
         arx_cnt_r <= 3'(`ACSP_CODE_BITS);
      end else if (a_fall && arx_cnt_r != 3'h0) begin
         arx_sh_r <= {arx_sh_r[2:0], arxi_s};
         arx_cnt_r <= arx_cnt_r - 3'h1;
      end
   end

   // A codeword waits here while the buffer is full.
   always_ff @(posedge clk) begin
      if (srst || hold) begin
         arx_pend_r <= 1'b0;
         arx_code_r <= 4'h0;
         dec_st_r <= '{pred: `ACSP_PRED_RST, scale: `ACSP_SCALE_RST};
      end else begin
         if (arx_done) begin
            arx_code_r <= {arx_sh_r[2:0], arxi_s};
            arx_pend_r <= 1'b1;
         end else if (dec_push) begin
            arx_pend_r <= 1'b0;
         end
         if (dec_push) dec_st_r <= dec_next;
      end
   end

   // -----------------------------------------------------------------------------
   // Two-entry buffer between decoder and receive serialiser
   // -----------------------------------------------------------------------------
   localparam int DEPTH = `ACSP_FIFO_DEPTH;
   logic [13:0] fifo_mem_r [DEPTH];
   logic fifo_wp_r;
   logic fifo_rp_r;
   logic [1:0] fifo_cnt_r;
   logic fifo_out_valid;
   logic fifo_pop;

   assign fifo_in_ready = (fifo_cnt_r != 2'(DEPTH));
   assign fifo_out_valid = (fifo_cnt_r != 2'h0);
   assign fifo_pop = p_rx_start & fifo_out_valid;

   always_ff @(posedge clk) begin
      if (srst || hold) begin
         fifo_wp_r <= 1'b0;
         fifo_rp_r <= 1'b0;
         fifo_cnt_r <= 2'h0;
      end else begin
         if (dec_push) fifo_mem_r[fifo_wp_r] <= dec_next.pred;
         if (dec_push) fifo_wp_r <= ~fifo_wp_r;
         if (fifo_pop) fifo_rp_r <= ~fifo_rp_r;
         fifo_cnt_r <= fifo_cnt_r + 2'(dec_push) - 2'(fifo_pop);
      end
   end

   // -----------------------------------------------------------------------------
   // Receive PCM serialiser
   // -----------------------------------------------------------------------------
   logic [13:0] prx_last_r;
   logic [13:0] prx_word;
   logic [13:0] prx_load;
   logic [13:0] prx_sh_r;
   logic pcm_rx_out_r;

   // An empty buffer repeats the last decoded sample; a decoder held in reset sends zero.
   assign prx_word = hold ? 14'h0000 :
                     (fifo_out_valid ? fifo_mem_r[fifo_rp_r] : prx_last_r);
   assign prx_load = law_s ? prx_word : {comp_encode(prx_word), 6'h00};

   always_ff @(posedge clk) begin
      if (srst || off) begin
         prx_last_r <= 14'h0000;
         prx_sh_r <= 14'h0000;
         pcm_rx_out_r <= 1'b0;
      end else if (p_rx_start) begin
         prx_last_r <= prx_word;
         prx_sh_r <= {prx_load[12:0], 1'b0};
         pcm_rx_out_r <= prx_load[13];
      end else if (p_rise) begin
         prx_sh_r <= {prx_sh_r[12:0], 1'b0};
         pcm_rx_out_r <= prx_sh_r[13];
      end
   end

   // -----------------------------------------------------------------------------
   // Receive PCM capture towards the converter
   // -----------------------------------------------------------------------------
   logic [13:0] prxi_sh_r;
   logic [3:0] prxi_cnt_r;
   logic [13:0] prxi_word;
   logic [13:0] dac_r;
   logic dac_valid_r;

   assign prxi_word = {prxi_sh_r[12:0], prxi_s};

   always_ff @(posedge clk) begin
      if (srst || off) begin
         prxi_sh_r <= 14'h0000;
         prxi_cnt_r <= 4'h0;
         dac_r <= 14'h0000;
         dac_valid_r <= 1'b0;
      end else begin
         dac_valid_r <= p_fall && (prxi_cnt_r == 4'h1);
         if (p_rx_start) begin
            prxi_cnt_r <= pcm_bits;
         end else if (p_fall && prxi_cnt_r != 4'h0) begin
            prxi_sh_r <= prxi_word;
            prxi_cnt_r <= prxi_cnt_r - 4'h1;
            if (prxi_cnt_r == 4'h1) dac_r <= law_s ? prxi_word : comp_decode(prxi_word[7:0]);
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Output registers
   // -----------------------------------------------------------------------------
   logic pd_r;

   always_ff @(posedge clk) begin
      if (srst) pd_r <= 1'b1;
      else pd_r <= off;
   end

   assign tx_sample_taken = taken_r;
   assign pcm_tx_out = pcm_tx_out_r;
   assign pcm_rx_out = pcm_rx_out_r;
   assign adpcm_tx_out_o = 1'b0; // Open drain only ever pulls low.
   assign adpcm_tx_out_oe = atx_oe_r;
   assign dac_sample = dac_r;
   assign dac_sample_valid = dac_valid_r;
   assign powered_down = pd_r;

endmodule : acsp_codec_port

// ==== logic/acsp_pkg.sv ====
package acsp_pkg;

   // Operating mode taken from the power-down and algorithm-reset pins.
   typedef enum logic [1:0] {
      ACSP_OFF,
      ACSP_INIT,
      ACSP_RUN
   } acsp_mode_t;

   // State carried between frames by the coder and by the decoder.
   typedef struct packed {
      logic signed [13:0] pred;
      logic [3:0] scale;
   } acsp_adpcm_t;

endpackage : acsp_pkg

// ==== logic/acsp_sync.sv ====
// Three-stage pin synchroniser with agreement filter.
module acsp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] d_async,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;
   logic [W-1:0] agree;

   // A bit is accepted only when the second and third stages agree.
   assign agree = ~(s2_r ^ s3_r);
   assign q = q_r;

   // The first stage feeds the second stage only.
   always_ff @(posedge clk) begin
      if (srst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r <= '0;
      end else begin
         s1_r <= d_async;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= (agree & s3_r) | (~agree & q_r);
      end
   end

endmodule : acsp_sync

// ==== verif/acsp_codec_port_asserts.sv ====
// ------------------------------------------------------------------
// Port checker
// ------------------------------------------------------------------
// Pin edges reach the outputs through a synchroniser, so edges are checked four cycles back.
module acsp_codec_port_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic power_down_n,
   input wire logic pcm_bit_clock,
   input wire logic adpcm_bit_clock,
   input wire logic tx_frame_sync,
   input wire logic tx_sample_taken,
   input wire logic pcm_tx_out,
   input wire logic pcm_rx_out,
   input wire logic adpcm_tx_out_o,
   input wire logic adpcm_tx_out_oe,
   input wire logic dac_sample_valid,
   input wire logic powered_down
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_drain_low_only: assert property (adpcm_tx_out_o == 1'b0)
      else $error("open-drain data is not low");
   a_pd_oe_off: assert property (powered_down |-> !adpcm_tx_out_oe)
      else $error("line pulled during power-down");
   a_pd_enter: assert property (!power_down_n [*8] |-> powered_down)
      else $error("power-down not entered");
   a_pd_leave: assert property (power_down_n [*8] |-> !powered_down)
      else $error("power-down not left");
   a_pd_quiet_out: assert property (powered_down && $past(powered_down) |->
      !pcm_tx_out && !pcm_rx_out && !tx_sample_taken && !dac_sample_valid)
      else $error("activity during power-down");
   a_tx_bit_rise: assert property ($changed(pcm_tx_out) && power_down_n &&
      !powered_down |-> $past(pcm_bit_clock, 4)) else $error("pcm tx bit off rise");
   a_rx_bit_rise: assert property ($changed(pcm_rx_out) && power_down_n &&
      !powered_down |-> $past(pcm_bit_clock, 4)) else $error("pcm rx bit off rise");
   a_code_bit_rise: assert property ($changed(adpcm_tx_out_oe) && power_down_n &&
      !powered_down |-> $past(adpcm_bit_clock, 4)) else $error("code bit off rise");
   a_taken_at_sync: assert property (tx_sample_taken |->
      $past(tx_frame_sync, 4) ##1 !tx_sample_taken) else $error("sample taken off sync");
   a_valid_on_fall: assert property (dac_sample_valid |->
      !$past(pcm_bit_clock, 4) ##1 !dac_sample_valid) else $error("capture off fall");
   c_taken: cover property (tx_sample_taken);
   c_valid: cover property (dac_sample_valid);
   c_code: cover property ($rose(adpcm_tx_out_oe));
   c_pd: cover property ($rose(powered_down));
endmodule : acsp_codec_port_chk

bind acsp_codec_port acsp_codec_port_chk i_chk (
   .clk(clk), .srst(srst), .power_down_n(power_down_n), .pcm_bit_clock(pcm_bit_clock),
   .adpcm_bit_clock(adpcm_bit_clock), .tx_frame_sync(tx_frame_sync),
   .tx_sample_taken(tx_sample_taken), .pcm_tx_out(pcm_tx_out), .pcm_rx_out(pcm_rx_out),
   .adpcm_tx_out_o(adpcm_tx_out_o), .adpcm_tx_out_oe(adpcm_tx_out_oe),
   .dac_sample_valid(dac_sample_valid), .powered_down(powered_down)
);

// ==== verif/acsp_ctl_model.sv ====
// ------------------------------------------------------------------
// Controller model
// ------------------------------------------------------------------
// Drives the shared bit clocks and both frame syncs. The clock stands still between frames.
module acsp_ctl_model (
   output logic pcm_bit_clock,
   output logic adpcm_bit_clock,
   output logic tx_frame_sync,
   output logic rx_frame_sync
);
   timeunit 1ns;
   timeprecision 100ps;
   logic bclk = 1'b0;
   logic fsync = 1'b0;
   // One shift clock serves both ports, and one sync marks the first slot both ways.
   assign pcm_bit_clock = bclk;
   assign adpcm_bit_clock = bclk;
   assign tx_frame_sync = fsync;
   assign rx_frame_sync = fsync;
   // Sixteen 64 ns slots per frame, with a phase unrelated to the system clock.
   initial begin
      #7.3;
      forever begin
         fsync = 1'b1;
         #8 bclk = 1'b1;
         #32 bclk = 1'b0;
         #8 fsync = 1'b0;
         #24;
         repeat (15) begin
            bclk = 1'b1;
            #32 bclk = 1'b0;
            #32;
         end
         #64;
      end
   end
endmodule : acsp_ctl_model

// ==== verif/tb_top.sv ====
// ------------------------------------------------------------------
// Testbench
// ------------------------------------------------------------------
// Loops PCM and ADPCM lines back through the block and judges selected frames at the pins.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic law_select = 1'b1;
   logic power_down_n = 1'b1;
   logic algorithm_init_n = 1'b1;
   logic sel_rx = 1'b0;
   logic [13:0] tx_sample_data = 14'h0000;
   logic pcm_bit_clock, adpcm_bit_clock, tx_frame_sync, rx_frame_sync;
   logic pcm_tx_out, pcm_rx_out, adpcm_tx_out_o, adpcm_tx_out_oe;
   logic tx_sample_taken, dac_sample_valid, powered_down, adpcm_line, pcm_rx_in;
   logic [13:0] dac_sample;
   int bad_count = 0;
   int cmp_count = 0;
   always #2 clk = ~clk;
   // Pull-up on the open-drain line; the decoder input listens to it.
   assign adpcm_line = adpcm_tx_out_oe ? adpcm_tx_out_o : 1'b1;
   assign pcm_rx_in = sel_rx ? pcm_rx_out : pcm_tx_out;
   acsp_ctl_model i_ctl (.pcm_bit_clock(pcm_bit_clock), .adpcm_bit_clock(adpcm_bit_clock),
      .tx_frame_sync(tx_frame_sync), .rx_frame_sync(rx_frame_sync));
   acsp_codec_port i_dut (.clk(clk), .srst(srst), .law_select(law_select),
      .power_down_n(power_down_n), .algorithm_init_n(algorithm_init_n),
      .pcm_bit_clock(pcm_bit_clock), .adpcm_bit_clock(adpcm_bit_clock),
      .tx_frame_sync(tx_frame_sync), .rx_frame_sync(rx_frame_sync), .pcm_tx_in(pcm_tx_out),
      .pcm_rx_in(pcm_rx_in), .adpcm_rx_in(adpcm_line), .tx_sample_data(tx_sample_data),
      .tx_sample_taken(tx_sample_taken), .pcm_tx_out(pcm_tx_out), .pcm_rx_out(pcm_rx_out),
      .adpcm_tx_out_o(adpcm_tx_out_o), .adpcm_tx_out_oe(adpcm_tx_out_oe),
      .dac_sample(dac_sample), .dac_sample_valid(dac_sample_valid),
      .powered_down(powered_down));

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic frames(input int n);
      repeat (n) @(posedge tx_frame_sync);
   endtask : frames

   // Samples both transmit lines at each of the sixteen falls of one frame.
   task automatic grab(output logic [15:0] p, output logic [15:0] a);
      @(posedge tx_frame_sync);
      repeat (16) begin
         @(negedge pcm_bit_clock);
         p = {p[14:0], pcm_tx_out};
         a = {a[14:0], adpcm_line};
      end
   endtask : grab

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic t_reset();
      repeat (6) @(posedge clk);
      @(negedge clk);
      check("reset powered_down", 16'h0001, {15'h0, powered_down});
      check("reset outputs", 16'h0000,
         {13'h0, pcm_tx_out, pcm_rx_out, adpcm_tx_out_oe});
      srst = 1'b0;
      $display("test reset done");
   endtask : t_reset

   // Every law with boundary levels: serial word, idle slots and captured sample.
   task automatic t_words();
      logic [13:0] vals [3] = '{14'h0000, 14'h1FFF, 14'h2000};
      logic [7:0] comp [3] = '{8'hD5, 8'hAA, 8'h2A};
      // Step midpoints that the companded characters above stand for.
      logic [13:0] comp_lin [3] = '{14'h0001, 14'h0FC0, 14'h3040};
      logic [15:0] p, a;
      for (int l = 0; l < 2; l++) begin
         for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            law_select = l[0];
            sel_rx = 1'b0;
            tx_sample_data = vals[i];
            frames(2);
            grab(p, a);
            if (l == 1) begin
               check("linear word", {vals[i], 2'b00}, p);
               check("linear capture", {2'b00, vals[i]}, {2'b00, dac_sample});
            end else begin
               check("companded word", {comp[i], 8'h00}, p);
               check("companded capture", {2'b00, comp_lin[i]}, {2'b00, dac_sample});
            end
            check("code idle slots", 16'h0FFF, {4'h0, a[11:0]});
         end
      end
      $display("test words done");
   endtask : t_words

   // Full loop: coder, ADPCM line, decoder, receive PCM line, capture.
   task automatic t_track(input logic [13:0] v, input logic neg);
      @(negedge clk);
      law_select = 1'b1;
      sel_rx = 1'b1;
      tx_sample_data = v;
      frames(30);
      check("decoded sign", {15'h0, neg}, {15'h0, dac_sample[13]});
      check("decoded nonzero", 16'h0001, {15'h0, |dac_sample});
      $display("test track done");
   endtask : t_track

   task automatic t_init();
      @(negedge clk);
      algorithm_init_n = 1'b0;
      repeat (31250) @(posedge clk);
      frames(3);
      check("decoded in reset", 16'h0000, {2'b00, dac_sample});
      @(negedge clk);
      algorithm_init_n = 1'b1;
      $display("test init done");
   endtask : t_init

   task automatic t_pd();
      logic [15:0] p, a;
      @(negedge clk);
      power_down_n = 1'b0;
      frames(2);
      grab(p, a);
      check("powered down", 16'h0001, {15'h0, powered_down});
      check("line released", 16'hFFFF, a);
      check("pcm quiet", 16'h0000, p);
      @(negedge clk);
      power_down_n = 1'b1;
      frames(2);
      check("powered up", 16'h0000, {15'h0, powered_down});
      $display("test power-down done");
   endtask : t_pd

   // Main sequence.
   initial begin
      t_reset();
      t_words();
      t_pd();
      t_track(14'h1000, 1'b0);
      t_track(14'h3000, 1'b1);
      t_init();
      t_track(14'h1000, 1'b0);
      close_out();
   end

   // Watchdog well beyond the expected run of about 252 us.
   initial begin
      #340000;
      bad_count++;
      $display("[FAIL] watchdog expected finish seen timeout");
      close_out();
   end
endmodule : tb_top
